// >>> verilog/motor_ctl.sv
// Purpose: Interlocked manual jog, indicators, brake drive and loop fault report.
// Assumes: Switch and sensor inputs are slow and are synchronised here.
// Notes:   Registers sit on a plain strobe port with read data one cycle later.
//
// Behaviour
// [RULE_01] Forward blocked on limit rise or held level.
// [RULE_02] Blocked: drive variant allows reverse; starter blocks manual.
// [RULE_03] Forward released by limit fall or auto round-trip.
// [RULE_04] Reverse limit mirrors forward limit behaviour exactly.
// [RULE_05] Edge-only setting: held limit does not block.
// [RULE_06] Indicator steady when selected and not blocked.
// [RULE_07] Indicator flashes when selected but interlock stops motor.
// [RULE_08] Brake boost at most 120 ms, then hold.
// [RULE_09] Starter variant releases brake with motor start.
// [RULE_10] Monitoring off: loop break raises fault and LED.
// [RULE_11] Monitoring on: loop break suppresses fault and LED.
// [RULE_12] Monitoring on in auto: break clears status bit 1.
// [RULE_13] Inputs synchronised before edge detection, edges once.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module motor_ctl #(
  parameter int unsigned BOOST_CYC = motor_ctl_pkg::BOOST_CYCLES,
  parameter int unsigned FLASH_CYC = motor_ctl_pkg::FLASH_HALF_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              srst,
  input  wire logic                              forward_limit_input,
  input  wire logic                              reverse_limit_input,
  input  wire logic                              sel_fwd,
  input  wire logic                              sel_rev,
  input  wire logic                              auto_mode,
  input  wire logic                              loop_ok,
  input  wire logic                              interlock_enable,
  input  wire logic                              variant_fc,
  input  wire logic                              fwd_edge_only_setting,
  input  wire logic                              rev_edge_only_setting,
  input  wire logic                              loop_monitor_setting,
  input  wire logic                              plc_run_fwd,
  input  wire logic                              plc_run_rev,
  input  wire logic                              fc_brake_release,
  input  wire logic [motor_ctl_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [motor_ctl_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [motor_ctl_pkg::DATA_W-1:0]  reg_rdata,
  output logic                                   motor_fwd,
  output logic                                   motor_rev,
  output logic                                   led_fwd,
  output logic                                   led_rev,
  output logic                                   brake_release,
  output logic                                   brake_boost,
  output logic                                   group_fault,
  output logic                                   motor_led,
  output logic      [motor_ctl_pkg::SDB_W-1:0]   slave_data_bits,
  output logic                                   irq
);

  logic [motor_ctl_pkg::SYNC_W-1:0] sync1_r;
  logic [motor_ctl_pkg::SYNC_W-1:0] sync1_nxt;
  logic [motor_ctl_pkg::SYNC_W-1:0] sync2_r;
  logic [motor_ctl_pkg::SYNC_W-1:0] sync2_nxt;
  logic [motor_ctl_pkg::SYNC_W-1:0] prev_r;
  logic [motor_ctl_pkg::SYNC_W-1:0] prev_nxt;

  logic [1:0]                       lim;
  logic [1:0]                       rise;
  logic [1:0]                       fall;
  logic [1:0]                       sel;
  logic [1:0]                       plc;
  logic [1:0]                       edge_only;
  logic [1:0]                       blocked;
  logic [1:0]                       manual_ok;
  logic                             auto_s;
  logic                             manual_il;
  logic                             loop_fault;

  logic [1:0]                       latch_r;
  logic [1:0]                       latch_nxt;
  logic [1:0]                       run_r;
  logic [1:0]                       run_nxt;
  logic [1:0]                       led_r;
  logic [1:0]                       led_nxt;
  logic [motor_ctl_pkg::CNT_W-1:0]  flash_cnt_r;
  logic [motor_ctl_pkg::CNT_W-1:0]  flash_cnt_nxt;
  logic                             flash_r;
  logic                             flash_nxt;

  motor_ctl_pkg::brake_state_t      brk_r;
  motor_ctl_pkg::brake_state_t      brk_nxt;
  logic [motor_ctl_pkg::CNT_W-1:0]  bcnt_r;
  logic [motor_ctl_pkg::CNT_W-1:0]  bcnt_nxt;
  logic                             rel_req;
  logic                             brake_rel_r;
  logic                             brake_rel_nxt;
  logic                             boost_r;
  logic                             boost_nxt;

  logic                             gfault_r;
  logic                             gfault_nxt;
  logic [motor_ctl_pkg::SDB_W-1:0]  sdb_r;
  logic [motor_ctl_pkg::SDB_W-1:0]  sdb_nxt;

  logic [motor_ctl_pkg::EV_W-1:0]   ev;
  logic [motor_ctl_pkg::EV_W-1:0]   status_r;
  logic [motor_ctl_pkg::EV_W-1:0]   status_nxt;
  logic [motor_ctl_pkg::EV_W-1:0]   enable_r;
  logic [motor_ctl_pkg::EV_W-1:0]   enable_nxt;
  logic [motor_ctl_pkg::DATA_W-1:0] rdata_r;
  logic [motor_ctl_pkg::DATA_W-1:0] rdata_nxt;
  logic                             irq_r;
  logic                             irq_nxt;

  // Two-flop synchroniser followed by a history stage for edge detection.
  always_comb begin
    sync1_nxt = {loop_ok, auto_mode, sel_rev, sel_fwd,
                 reverse_limit_input, forward_limit_input};
    sync2_nxt = sync1_r; // [RULE_13]
    prev_nxt  = sync2_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= motor_ctl_pkg::SYNC_RST;
      sync2_r <= motor_ctl_pkg::SYNC_RST;
      prev_r  <= motor_ctl_pkg::SYNC_RST;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // Interlock, direction drive and indicators.
  always_comb begin
    lim        = sync2_r[motor_ctl_pkg::SI_REV_LIM:motor_ctl_pkg::SI_FWD_LIM];
    rise       = lim & ~prev_r[motor_ctl_pkg::SI_REV_LIM:motor_ctl_pkg::SI_FWD_LIM]; // [RULE_13]
    fall       = ~lim & prev_r[motor_ctl_pkg::SI_REV_LIM:motor_ctl_pkg::SI_FWD_LIM];
    sel        = sync2_r[motor_ctl_pkg::SI_SEL_REV:motor_ctl_pkg::SI_SEL_FWD];
    auto_s     = sync2_r[motor_ctl_pkg::SI_AUTO];
    plc        = {plc_run_rev, plc_run_fwd};
    edge_only  = {rev_edge_only_setting, fwd_edge_only_setting};
    manual_il  = interlock_enable & ~auto_s;
    for (int d = 0; d < 2; d++) begin
      latch_nxt[d] = latch_r[d];
      if (auto_s || !interlock_enable || fall[d]) begin
        latch_nxt[d] = 1'b0; // [RULE_03] [RULE_04]
      end
      if (manual_il && rise[d]) begin
        latch_nxt[d] = 1'b1; // [RULE_01] [RULE_04]
      end
      blocked[d] = latch_r[d] | (manual_il & rise[d])
                 | (manual_il & lim[d] & ~edge_only[d]); // [RULE_01] [RULE_05]
    end
    for (int d = 0; d < 2; d++) begin
      manual_ok[d] = ~blocked[d] & (variant_fc | ~blocked[1-d]); // [RULE_02]
      if (auto_s) begin
        run_nxt[d] = plc[d] & ~plc[1-d];
        led_nxt[d] = plc[d] & ~plc[1-d];
      end else begin
        run_nxt[d] = sel[d] & ~sel[1-d] & manual_ok[d];
        led_nxt[d] = sel[d] & ~sel[1-d] & (manual_ok[d] | flash_r); // [RULE_06] [RULE_07]
      end
    end
    if (flash_cnt_r == motor_ctl_pkg::CNT_W'(FLASH_CYC - 1)) begin
      flash_cnt_nxt = '0;
      flash_nxt     = ~flash_r;
    end else begin
      flash_cnt_nxt = flash_cnt_r + motor_ctl_pkg::CNT_W'(1);
      flash_nxt     = flash_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      latch_r     <= 2'h0;
      run_r       <= 2'h0;
      led_r       <= 2'h0;
      flash_cnt_r <= '0;
      flash_r     <= 1'b0;
    end else begin
      latch_r     <= latch_nxt;
      run_r       <= run_nxt;
      led_r       <= led_nxt;
      flash_cnt_r <= flash_cnt_nxt;
      flash_r     <= flash_nxt;
    end
  end

  // Brake: a boost phase of bounded length, then the holding level.
  always_comb begin
    rel_req   = variant_fc ? fc_brake_release : (|run_nxt); // [RULE_09]
    brk_nxt   = brk_r;
    bcnt_nxt  = bcnt_r;
    case (brk_r)
      motor_ctl_pkg::BRK_APPLIED: begin
        bcnt_nxt = '0;
        if (rel_req) begin
          brk_nxt = motor_ctl_pkg::BRK_BOOST;
        end
      end
      motor_ctl_pkg::BRK_BOOST: begin
        bcnt_nxt = bcnt_r + motor_ctl_pkg::CNT_W'(1);
        if (!rel_req) begin
          brk_nxt = motor_ctl_pkg::BRK_APPLIED;
        end else if (bcnt_r == motor_ctl_pkg::CNT_W'(BOOST_CYC - 1)) begin
          brk_nxt = motor_ctl_pkg::BRK_HOLD; // [RULE_08]
        end
      end
      motor_ctl_pkg::BRK_HOLD: begin
        if (!rel_req) begin
          brk_nxt = motor_ctl_pkg::BRK_APPLIED;
        end
      end
      default: begin
        brk_nxt = motor_ctl_pkg::BRK_APPLIED;
      end
    endcase
    brake_rel_nxt = rel_req;
    boost_nxt     = rel_req & (brk_nxt == motor_ctl_pkg::BRK_BOOST); // [RULE_08]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      brk_r       <= motor_ctl_pkg::BRK_APPLIED;
      bcnt_r      <= '0;
      brake_rel_r <= 1'b0;
      boost_r     <= 1'b0;
    end else begin
      brk_r       <= brk_nxt;
      bcnt_r      <= bcnt_nxt;
      brake_rel_r <= brake_rel_nxt;
      boost_r     <= boost_nxt;
    end
  end

  // Loop monitoring, fault indication and slave data bits.
  always_comb begin
    loop_fault = ~sync2_r[motor_ctl_pkg::SI_LOOP_OK];
    gfault_nxt = loop_fault & ~loop_monitor_setting; // [RULE_10] [RULE_11]
    sdb_nxt    = {gfault_nxt, lim[motor_ctl_pkg::DIR_REV], 1'b1, lim[motor_ctl_pkg::DIR_FWD]};
    if (loop_monitor_setting && auto_s && loop_fault) begin
      sdb_nxt[motor_ctl_pkg::SDB_LOOP_OK] = 1'b0; // [RULE_12]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gfault_r <= 1'b0;
      sdb_r    <= 4'h2;
    end else begin
      gfault_r <= gfault_nxt;
      sdb_r    <= sdb_nxt;
    end
  end

  // Register port with sticky event flags; a new event wins over its clear.
  always_comb begin
    ev                          = '0;
    ev[motor_ctl_pkg::EV_FWD]   = manual_il & rise[motor_ctl_pkg::DIR_FWD];
    ev[motor_ctl_pkg::EV_REV]   = manual_il & rise[motor_ctl_pkg::DIR_REV];
    ev[motor_ctl_pkg::EV_LOOP]  = loop_fault & prev_r[motor_ctl_pkg::SI_LOOP_OK];
    status_nxt = status_r;
    enable_nxt = enable_r;
    if (reg_wr && reg_addr == motor_ctl_pkg::ADDR_CLEAR) begin
      status_nxt = status_r & ~reg_wdata[motor_ctl_pkg::EV_W-1:0];
    end
    if (reg_wr && reg_addr == motor_ctl_pkg::ADDR_ENABLE) begin
      enable_nxt = reg_wdata[motor_ctl_pkg::EV_W-1:0];
    end
    status_nxt = status_nxt | ev;
    irq_nxt    = |(status_nxt & enable_nxt);
    rdata_nxt  = '0;
    if (reg_rd) begin
      case (reg_addr)
        motor_ctl_pkg::ADDR_STATUS: rdata_nxt = {5'h00, status_r};
        motor_ctl_pkg::ADDR_ENABLE: rdata_nxt = {5'h00, enable_r};
        motor_ctl_pkg::ADDR_STATE:  rdata_nxt = {2'h0, loop_fault, auto_s, run_r, latch_r};
        default:                    rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_r <= '0;
      enable_r <= motor_ctl_pkg::EV_ENABLE_RST;
      rdata_r  <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      rdata_r  <= rdata_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign reg_rdata       = rdata_r;
  assign motor_fwd       = run_r[motor_ctl_pkg::DIR_FWD];
  assign motor_rev       = run_r[motor_ctl_pkg::DIR_REV];
  assign led_fwd         = led_r[motor_ctl_pkg::DIR_FWD];
  assign led_rev         = led_r[motor_ctl_pkg::DIR_REV];
  assign brake_release   = brake_rel_r;
  assign brake_boost     = boost_r;
  assign group_fault     = gfault_r;
  assign motor_led       = gfault_r;
  assign slave_data_bits = sdb_r;
  assign irq             = irq_r;

  // Checks of the documented behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic [motor_ctl_pkg::CNT_W:0] boost_len_r;
  always_ff @(posedge clk) begin
    if (srst || !boost_r) begin
      boost_len_r <= '0;
    end else begin
      boost_len_r <= boost_len_r + (motor_ctl_pkg::CNT_W+1)'(1);
    end
  end

  a_fwd_rise_block: assert property ( // [RULE_01]
    (manual_il && rise[0]) |=> !motor_fwd)
    else $error("Forward ran after a forward limit rise.");

  a_starter_both_off: assert property ( // [RULE_02]
    (!variant_fc && !auto_s && (|blocked)) |=> (!motor_fwd && !motor_rev))
    else $error("Starter variant ran manually while blocked.");

  a_fwd_fall_release: assert property ( // [RULE_03]
    (fall[0] && !rise[0]) |=> !latch_r[0])
    else $error("Forward block kept after limit fall.");

  a_rev_rise_block: assert property ( // [RULE_04]
    (manual_il && rise[1]) |=> !motor_rev)
    else $error("Reverse ran after a reverse limit rise.");

  a_auto_clears_block: assert property ( // [RULE_03]
    auto_s |=> (latch_r == 2'h0))
    else $error("Direction block survived automatic mode.");

  a_led_steady: assert property ( // [RULE_06]
    (!auto_s && sel[0] && !sel[1] && manual_ok[0]) |=> (led_fwd && motor_fwd))
    else $error("Forward indicator not steady while allowed.");

  a_led_flash: assert property ( // [RULE_07]
    (!auto_s && sel[0] && !sel[1] && !manual_ok[0]) |=> (led_fwd == $past(flash_r) && !motor_fwd))
    else $error("Forward indicator not flashing while blocked.");

  a_boost_bound: assert property ( // [RULE_08]
    boost_r |-> (boost_len_r < (motor_ctl_pkg::CNT_W+1)'(BOOST_CYC)) && brake_rel_r)
    else $error("Brake boost ran too long.");

  a_starter_brake: assert property ( // [RULE_09]
    !$past(variant_fc) |-> (brake_release == (motor_fwd || motor_rev)))
    else $error("Starter brake not tied to motor start.");

  a_fault_shown: assert property ( // [RULE_10]
    (loop_fault && !loop_monitor_setting) |=> (group_fault && motor_led))
    else $error("Loop break not shown as group fault.");

  a_fault_hidden: assert property ( // [RULE_11]
    loop_monitor_setting |=> (!group_fault && !motor_led))
    else $error("Group fault shown while suppressed.");

  a_sdb_cleared: assert property ( // [RULE_12]
    (loop_monitor_setting && auto_s && loop_fault) |=> !slave_data_bits[1])
    else $error("Status bit 1 not cleared on loop break.");

  a_edge_once: assert property ( // [RULE_13]
    rise[0] |=> !rise[0])
    else $error("Limit edge seen twice.");

  c_fwd_blocked: cover property (manual_il && rise[0] && sel[0]);
  c_flash_led:   cover property (!auto_s && sel[1] && !manual_ok[1] ##1 led_rev);
  c_boost_hold:  cover property (brk_r == motor_ctl_pkg::BRK_BOOST ##1 brk_r == motor_ctl_pkg::BRK_HOLD);
  c_sdb_clear:   cover property (loop_monitor_setting && auto_s && loop_fault);

endmodule

`default_nettype wire

// >>> verilog/motor_ctl_pkg.sv
// Purpose: Shared constants and types for the interlocked manual motor control block.
// Assumes: A 100 MHz system clock.
// Notes:   Long cycle counts are defaults for parameters of the top module.
`default_nettype none

package motor_ctl_pkg;

  localparam int CLK_HZ            = 100_000_000;
  localparam int CLK_PER_MS        = CLK_HZ / 1000;
  localparam int BOOST_MAX_MS      = 120;
  localparam int BOOST_CYCLES      = BOOST_MAX_MS * CLK_PER_MS;
  localparam int FLASH_HALF_MS     = 250;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_PER_MS;
  localparam int CNT_W             = 25;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CLEAR  = 2'h1;
  localparam logic [1:0] ADDR_ENABLE = 2'h2;
  localparam logic [1:0] ADDR_STATE  = 2'h3;

  localparam int EV_W    = 3;
  localparam int EV_FWD  = 0;
  localparam int EV_REV  = 1;
  localparam int EV_LOOP = 2;
  localparam logic [2:0] EV_ENABLE_RST = 3'h0;

  localparam int DIR_FWD = 0;
  localparam int DIR_REV = 1;

  localparam int SYNC_W     = 6;
  localparam int SI_FWD_LIM = 0;
  localparam int SI_REV_LIM = 1;
  localparam int SI_SEL_FWD = 2;
  localparam int SI_SEL_REV = 3;
  localparam int SI_AUTO    = 4;
  localparam int SI_LOOP_OK = 5;
  localparam logic [5:0] SYNC_RST = 6'h20;

  localparam int SDB_W       = 4;
  localparam int SDB_LOOP_OK = 1;

  typedef enum logic [1:0] {
    BRK_APPLIED = 2'b00,
    BRK_BOOST   = 2'b01,
    BRK_HOLD    = 2'b10
  } brake_state_t;

endpackage

`default_nettype wire

// >>> tb/travel_model.sv
// Purpose: Axis travel model with the two limit switches at its ends.
// Assumes: One position step per clock while exactly one drive is on.
// Notes:   A preset pulse moves the axis at once to a chosen position.
`timescale 1ns/1ns
`default_nettype none

module travel_model #(
  parameter int unsigned END_POS = 1000
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       motor_fwd,
  input  wire logic       motor_rev,
  input  wire logic       preset,
  input  wire logic [9:0] preset_pos,
  output logic            forward_limit_input,
  output logic            reverse_limit_input
);
  logic [9:0] pos_r;
  logic [9:0] pos_nxt;

  always_comb begin
    pos_nxt = pos_r;
    if (preset) begin
      pos_nxt = preset_pos;
    end else if (motor_fwd && !motor_rev && pos_r < 10'(END_POS)) begin
      pos_nxt = pos_r + 10'h1;
    end else if (motor_rev && !motor_fwd && pos_r != 10'h0) begin
      pos_nxt = pos_r - 10'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pos_r <= 10'h1f4;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // The switches stay closed while the axis rests at an end.
  assign forward_limit_input = (pos_r >= 10'(END_POS));
  assign reverse_limit_input = (pos_r == 10'h0);
endmodule

`default_nettype wire

// >>> tb/test_interlocked_manual_motor_control.sv
// Purpose: Self-checking bench for the interlocked manual motor control block.
// Assumes: Short boost and flash counts set through parameters.
// Notes:   The axis model closes the limit switches from the motor drive.
`timescale 1ns/1ns
`default_nettype none

module test_interlocked_manual_motor_control;
  localparam int BOOST = 20;
  localparam int FLASH = 4;
  localparam logic [9:0] END_POS = 10'h3e8;
  logic       clk, srst, sel_fwd, sel_rev, auto_mode, loop_ok, interlock_enable;
  logic       variant_fc, fwd_edge_only_setting, rev_edge_only_setting, loop_monitor_setting;
  logic       plc_run_fwd, plc_run_rev, reg_wr, reg_rd, preset, flim, rlim;
  logic       motor_fwd, motor_rev, led_fwd, led_rev, brake_release, brake_boost;
  logic       group_fault, motor_led, irq;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] slave_data_bits;
  logic [9:0] preset_pos;
  int         error_cnt = 0;
  int         comparisons = 0;
  // Rows: {auto, variant, sel_fwd, sel_rev, plc_fwd, plc_rev}, position, {rev, fwd}.
  logic [5:0] row_in [8] = '{6'h08, 6'h08, 6'h04, 6'h14, 6'h14, 6'h22, 6'h23, 6'h0c};
  logic [9:0] row_pos [8] = '{10'h1f4, END_POS, END_POS, END_POS, 10'h0, 10'h1f4, 10'h1f4,
                              10'h1f4};
  logic [1:0] row_exp [8] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};

  motor_ctl #(.BOOST_CYC(BOOST), .FLASH_CYC(FLASH)) DUT (
    .clk(clk), .srst(srst), .forward_limit_input(flim), .reverse_limit_input(rlim),
    .sel_fwd(sel_fwd), .sel_rev(sel_rev), .auto_mode(auto_mode), .loop_ok(loop_ok),
    .interlock_enable(interlock_enable), .variant_fc(variant_fc),
    .fwd_edge_only_setting(fwd_edge_only_setting),
    .rev_edge_only_setting(rev_edge_only_setting),
    .loop_monitor_setting(loop_monitor_setting), .plc_run_fwd(plc_run_fwd),
    .plc_run_rev(plc_run_rev), .fc_brake_release(1'b0), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .motor_fwd(motor_fwd), .motor_rev(motor_rev), .led_fwd(led_fwd), .led_rev(led_rev),
    .brake_release(brake_release), .brake_boost(brake_boost), .group_fault(group_fault),
    .motor_led(motor_led), .slave_data_bits(slave_data_bits), .irq(irq));

  travel_model #(.END_POS(1000)) axis (
    .clk(clk), .srst(srst), .motor_fwd(motor_fwd), .motor_rev(motor_rev), .preset(preset),
    .preset_pos(preset_pos), .forward_limit_input(flim), .reverse_limit_input(rlim));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_pos(input logic [9:0] p);
    preset     <= 1'b1;
    preset_pos <= p;
    @(posedge clk);
    preset <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask

  task automatic flashes(output int n);
    logic prev;
    n = 0;
    repeat (4 * FLASH) begin
      prev = led_fwd;
      cyc(1);
      if (led_fwd !== prev) n++;
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #50000;
    error_cnt++;
    conclude();
  end

  initial begin
    int n;
    {srst, loop_ok, interlock_enable} = 3'b111;
    {sel_fwd, sel_rev, auto_mode, variant_fc, plc_run_fwd, plc_run_rev} = 6'h0;
    {fwd_edge_only_setting, rev_edge_only_setting, loop_monitor_setting} = 3'h0;
    {reg_wr, reg_rd, preset, reg_addr, reg_wdata, preset_pos} = '0;
    cyc(4);
    check("reset outputs", {motor_fwd, motor_rev, led_fwd, led_rev, brake_release,
                            brake_boost, group_fault, irq}, 8'h00);
    check("reset sdb", {4'h0, slave_data_bits}, 8'h02);
    @(posedge clk);
    srst <= 1'b0;
    rd(motor_ctl_pkg::ADDR_ENABLE, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {auto_mode, variant_fc, sel_fwd, sel_rev, plc_run_fwd, plc_run_rev} <= row_in[i];
      set_pos(row_pos[i]);
      cyc(6);
      check("motor", {6'h0, motor_rev, motor_fwd}, {6'h0, row_exp[i]});
      if (row_exp[i] != 2'h0) begin
        check("led", {6'h0, led_rev, led_fwd}, {6'h0, row_exp[i]});
      end
    end
    $display("test rows done");
    @(posedge clk);
    {sel_fwd, sel_rev, fwd_edge_only_setting} <= 3'b101;
    set_pos(END_POS);
    cyc(6);
    check("edge block", {7'h0, motor_fwd}, 8'h00);
    flashes(n);
    check("flash", 8'(n), 8'h04);
    @(posedge clk);
    auto_mode <= 1'b1;
    cyc(6);
    @(posedge clk);
    auto_mode <= 1'b0;
    cyc(6);
    check("round trip", {7'h0, motor_fwd}, 8'h01);
    flashes(n);
    check("steady", {7'(n), led_fwd}, 8'h01);
    @(posedge clk);
    set_pos(10'h3c0);
    @(posedge clk);
    set_pos(END_POS);
    cyc(6);
    check("rise block", {7'h0, motor_fwd}, 8'h00);
    @(posedge clk);
    set_pos(10'h3c0);
    cyc(6);
    check("fall release", {7'h0, motor_fwd}, 8'h01);
    $display("test interlock done");
    @(posedge clk);
    sel_fwd <= 1'b0;
    cyc(6);
    check("brake off", {7'h0, brake_release}, 8'h00);
    @(posedge clk);
    sel_fwd <= 1'b1;
    set_pos(10'h1f4);
    n = 0;
    while (motor_fwd !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    check("brake start", {6'h0, brake_release, brake_boost}, 8'h03);
    n = 0;
    while (brake_boost === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("boost length", 8'(n), 8'(BOOST));
    check("brake hold", {7'h0, brake_release}, 8'h01);
    $display("test brake done");
    @(posedge clk);
    {sel_fwd, auto_mode, loop_monitor_setting, loop_ok} <= 4'b0110;
    cyc(6);
    check("suppressed", {5'h0, group_fault, motor_led, slave_data_bits[1]}, 8'h00);
    @(posedge clk);
    loop_monitor_setting <= 1'b0;
    cyc(6);
    check("fault shown", {6'h0, group_fault, motor_led}, 8'h03);
    @(posedge clk);
    {loop_ok, auto_mode} <= 2'b10;
    cyc(6);
    $display("test loop done");
    rd(motor_ctl_pkg::ADDR_STATUS, 8'h07);
    wr(motor_ctl_pkg::ADDR_ENABLE, 8'h04);
    cyc(1);
    check("irq on", {7'h0, irq}, 8'h01);
    wr(motor_ctl_pkg::ADDR_ENABLE, 8'h00);
    cyc(1);
    check("irq masked", {7'h0, irq}, 8'h00);
    wr(motor_ctl_pkg::ADDR_ENABLE, 8'h07);
    wr(motor_ctl_pkg::ADDR_CLEAR, 8'h07);
    cyc(1);
    check("irq cleared", {7'h0, irq}, 8'h00);
    rd(motor_ctl_pkg::ADDR_STATUS, 8'h00);
    rd(motor_ctl_pkg::ADDR_CLEAR, 8'h00);
    rd(motor_ctl_pkg::ADDR_ENABLE, 8'h07);
    $display("test registers done");
    conclude();
  end
endmodule

`default_nettype wire
